// ---- core/spvcr_cfg.svh ----
// Offsets, field positions, reset values and access masks for the port vendor config bank
`ifndef SPVCR_CFG_SVH
`define SPVCR_CFG_SVH

`define SPVCR_OFS_TLC       8'h8C
`define SPVCR_OFS_PHY3      8'h90
`define SPVCR_OFS_PHY4      8'h94
`define SPVCR_OFS_OPM       8'h98

`define SPVCR_RST_TLC       32'h0079_1894
`define SPVCR_RST_PHY3      32'h0000_8000
`define SPVCR_RST_PHY4      32'h0000_116B
`define SPVCR_RST_OPM       32'h001F_0122

// Bits software may write in the control word
`define SPVCR_TLC_WMASK     32'h0000_0060
// Bits that exist at all (reserved read zero)
`define SPVCR_TLC_VMASK     32'hBFFF_1FFF
`define SPVCR_PHY3_VMASK    32'hFFFF_807F
`define SPVCR_PHY4_VMASK    32'h0000_FFFF
`define SPVCR_OPM_VMASK     32'h0FFF_01FF
// Upstream-only fields, shared from the upstream port
`define SPVCR_TLC_UPMASK    32'h3C00_18EF
`define SPVCR_PHY3_UPMASK   32'hFFFF_8000
`define SPVCR_OPM_UPMASK    32'h00FF_0000

`define SPVCR_BIT_NO_RELAX  6
`define SPVCR_BIT_PORT_DIS  10
`define SPVCR_BIT_RST_SEL   11
`define SPVCR_LSB_RATE_CNT  8
`define SPVCR_BIT_RETRAIN   16
`define SPVCR_BIT_CLKPD     23
`define SPVCR_LSB_REFCLK_EN 16
`define SPVCR_LSB_LANE_MODE 0
`define SPVCR_LSB_DELTA     15
// Edges after reset release before all strap stages hold the pin
`define SPVCR_STRAP_FILL    2'h3

`endif

// ---- core/spvcr_pkg.sv ----
// Types shared by the port vendor config bank
package spvcr_pkg;
  typedef enum logic [1:0] {
    SPVCR_SEL_TLC,
    SPVCR_SEL_PHY3,
    SPVCR_SEL_PHY4,
    SPVCR_SEL_OPM
  } spvcr_sel_type;
endpackage

// ---- core/spvcr_regs.sv ----
// Per-port vendor configuration register bank with sideband load and upstream sharing
`timescale 1ns/1ns
`include "spvcr_cfg.svh"

module spvcr_regs #(
  parameter int NPORTS = 3
) (
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     sys_rst,
  // Strap pin, asynchronous to core_clk
  input  wire logic                     clock_buffer_powerdown_strap,
  // Configuration access from the port's config space
  input  wire logic                     cfg_wr,
  input  wire logic                     cfg_rd,
  input  wire logic [1:0]               cfg_port,
  input  wire logic [7:0]               cfg_addr,
  input  wire logic [31:0]              cfg_wdata,
  output logic      [31:0]              cfg_rdata,
  output logic                          cfg_rvalid,
  // Sideband (SMBus/I2C or EEPROM autoload) default override
  input  wire logic                     sb_wr,
  input  wire logic [1:0]               sb_port,
  input  wire logic [7:0]               sb_addr,
  input  wire logic [31:0]              sb_wdata,
  // Decoded controls, per port
  output logic [NPORTS-1:0]             relaxed_order_off,
  output logic [NPORTS-1:0]             port_disabled,
  output logic [NPORTS-1:0]             retrain_on_err_off,
  output logic [NPORTS*2-1:0]           rate_change_attempt_count,
  output logic [NPORTS*7-1:0]           phy_lane_mode,
  // Global controls taken from the upstream port
  output logic                          upstream_cfg_keep,
  output logic [16:0]                   phy_delta,
  output logic [15:0]                   phy_tx_margin,
  output logic [15:0]                   strap_modes,
  output logic [6:0]                    reference_clock_outputs_en,
  output logic                          reference_clock_outputs_pd
);

  // Storage per port and register
  // Each port keeps a full copy; downstream copies of upstream-only fields load but are never read
  logic [31:0] tlc_q  [NPORTS];
  logic [31:0] phy3_q [NPORTS];
  logic [31:0] phy4_q [NPORTS];
  logic [31:0] opm_q  [NPORTS];

  // Strap synchroniser and capture after reset release
  logic [2:0]  strap_sync_q;
  logic        strap_done_q;
  // Counts edges until all three stages hold the pin rather than reset zeros
  logic [1:0]  strap_fill_q;

  // Offset decode; hit is low for any offset outside this bank
  function automatic spvcr_pkg::spvcr_sel_type dec(input logic [7:0] a, output logic hit);
    hit = 1'b1;
    case (a)
      `SPVCR_OFS_TLC:  dec = spvcr_pkg::SPVCR_SEL_TLC;
      `SPVCR_OFS_PHY3: dec = spvcr_pkg::SPVCR_SEL_PHY3;
      `SPVCR_OFS_PHY4: dec = spvcr_pkg::SPVCR_SEL_PHY4;
      `SPVCR_OFS_OPM:  dec = spvcr_pkg::SPVCR_SEL_OPM;
      default: begin
        hit = 1'b0;
        dec = spvcr_pkg::SPVCR_SEL_TLC;
      end
    endcase
  endfunction

  // Merge per-port bits with the upstream port's copy of shared fields
  function automatic logic [31:0] merge(input logic [31:0] own, input logic [31:0] up, input logic [31:0] m);
    merge = (own & ~m) | (up & m);
  endfunction

  // Port index check; an index beyond the bank is dropped rather than aliased
  function automatic logic port_ok(input logic [1:0] p);
    port_ok = int'(p) < NPORTS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Strap: three flops, change counts once stages two and three agree
  // Reset zeros in the stages are not pin levels, hence the fill counter
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_sync_q <= 3'h0;
      strap_fill_q <= 2'h0;
    end else begin
      strap_sync_q <= {strap_sync_q[1:0], clock_buffer_powerdown_strap};
      // Saturates; the capture waits for it so reset zeros are never taken as the pin
      if (strap_fill_q != `SPVCR_STRAP_FILL) begin
        strap_fill_q <= strap_fill_q + 2'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register storage: reset defaults, sideband load, config writes
  // Both buses decoded every cycle; the strobes, hit flags and port checks decide whether a result is used
  logic                     sb_hit;
  logic                     cfg_hit;
  spvcr_pkg::spvcr_sel_type sb_sel;
  spvcr_pkg::spvcr_sel_type cfg_sel;
  always_comb begin
    sb_sel  = dec(sb_addr, sb_hit);
    cfg_sel = dec(cfg_addr, cfg_hit);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      // Bit 23 keeps its reset zero until the strap is captured
      for (int p = 0; p < NPORTS; p++) begin
        tlc_q[p]  <= `SPVCR_RST_TLC;
        phy3_q[p] <= `SPVCR_RST_PHY3;
        phy4_q[p] <= `SPVCR_RST_PHY4;
        opm_q[p]  <= `SPVCR_RST_OPM;
      end
    end else begin
      // strap sampled into bit 23
      // Only the first capture after reset counts; later pin changes are ignored
      if (!strap_done_q && strap_fill_q == `SPVCR_STRAP_FILL && strap_sync_q[2] == strap_sync_q[1]) begin
        strap_done_q <= 1'b1;
        // All copies take the pin; only the upstream one reaches the output
        for (int p = 0; p < NPORTS; p++) begin
          opm_q[p][`SPVCR_BIT_CLKPD] <= strap_sync_q[2];
        end
      end
      // Only bits 5 and 6 take a software write; the rest is written back as it was
      // software touches only writable bits
      if (cfg_wr && cfg_hit && cfg_sel == spvcr_pkg::SPVCR_SEL_TLC && port_ok(cfg_port)) begin
        tlc_q[cfg_port] <= (tlc_q[cfg_port] & ~`SPVCR_TLC_WMASK) | (cfg_wdata & `SPVCR_TLC_WMASK);
      end
      // sideband overrides defaults; later in block so it wins a clash
      // Full-word load; reserved bits are masked so they keep reading zero
      if (sb_wr && sb_hit && port_ok(sb_port)) begin
        unique case (sb_sel)
          spvcr_pkg::SPVCR_SEL_TLC:  tlc_q[sb_port]  <= sb_wdata & `SPVCR_TLC_VMASK;
          spvcr_pkg::SPVCR_SEL_PHY3: phy3_q[sb_port] <= sb_wdata & `SPVCR_PHY3_VMASK;
          spvcr_pkg::SPVCR_SEL_PHY4: phy4_q[sb_port] <= sb_wdata & `SPVCR_PHY4_VMASK;
          spvcr_pkg::SPVCR_SEL_OPM:  opm_q[sb_port]  <= sb_wdata & `SPVCR_OPM_VMASK;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read path, one cycle latency; unmapped reads zero
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_rdata  <= 32'h0000_0000;
      cfg_rvalid <= 1'b0;
    end else begin
      // Every read is answered, unmapped ones with zero data
      cfg_rvalid <= cfg_rd;
      // Zero outside the valid cycle, so several banks can share one OR-ed return bus
      cfg_rdata  <= 32'h0000_0000;
      if (cfg_rd && cfg_hit && port_ok(cfg_port)) begin
        // shared fields read from upstream copy
        unique case (cfg_sel)
          spvcr_pkg::SPVCR_SEL_TLC:  cfg_rdata <= merge(tlc_q[cfg_port], tlc_q[0], `SPVCR_TLC_UPMASK);
          spvcr_pkg::SPVCR_SEL_PHY3: cfg_rdata <= merge(phy3_q[cfg_port], phy3_q[0], `SPVCR_PHY3_UPMASK);
          // Margin word exists once, so every port reads the upstream copy
          spvcr_pkg::SPVCR_SEL_PHY4: cfg_rdata <= phy4_q[0];
          spvcr_pkg::SPVCR_SEL_OPM:  cfg_rdata <= merge(opm_q[cfg_port], opm_q[0], `SPVCR_OPM_UPMASK);
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-port decoded controls
  // One cycle behind storage, so consumers see a settled level and never a write in flight
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      relaxed_order_off         <= '0;
      port_disabled             <= '0;
      // Mirror byte resets to 0x79, so its low bit has retraining off on every port
      retrain_on_err_off        <= '1;
      rate_change_attempt_count <= '0;
      phy_lane_mode             <= '0;
    end else begin
      for (int p = 0; p < NPORTS; p++) begin
        relaxed_order_off[p] <= tlc_q[0][`SPVCR_BIT_NO_RELAX];
        port_disabled[p] <= tlc_q[p][`SPVCR_BIT_PORT_DIS];
        retrain_on_err_off[p] <= tlc_q[p][`SPVCR_BIT_RETRAIN];
        rate_change_attempt_count[p*2 +: 2] <= tlc_q[p][`SPVCR_LSB_RATE_CNT +: 2];
        phy_lane_mode[p*7 +: 7] <= phy3_q[p][`SPVCR_LSB_LANE_MODE +: 7];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Global controls taken from the upstream port
  // Downstream copies of these fields are ignored; the upstream copy drives the whole chip
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // Defaults match the reset words of the upstream copy
      upstream_cfg_keep          <= 1'b1;
      phy_delta                  <= 17'h0_0001;
      phy_tx_margin              <= 16'h116B;
      strap_modes                <= 16'h0122;
      reference_clock_outputs_en <= 7'h1F;
      reference_clock_outputs_pd <= 1'b0;
    end else begin
      upstream_cfg_keep <= tlc_q[0][`SPVCR_BIT_RST_SEL];
      phy_delta <= phy3_q[0][`SPVCR_LSB_DELTA +: 17];
      phy_tx_margin <= phy4_q[0][15:0];
      strap_modes <= opm_q[0][15:0];
      reference_clock_outputs_en <= opm_q[0][`SPVCR_LSB_REFCLK_EN +: 7];
      reference_clock_outputs_pd <= opm_q[0][`SPVCR_BIT_CLKPD];
    end
  end

endmodule

// ---- verif/spvcr_props.sv ----
// Concurrent checks on the port vendor config bank ports
`timescale 1ns/1ns
`include "spvcr_cfg.svh"
module spvcr_props #(parameter int NPORTS = 3) (
  // Clock, reset and access
  input wire logic              core_clk,
  input wire logic              sys_rst,
  input wire logic              cfg_wr,
  input wire logic              cfg_rd,
  input wire logic [1:0]        cfg_port,
  input wire logic [7:0]        cfg_addr,
  input wire logic [31:0]       cfg_wdata,
  input wire logic [31:0]       cfg_rdata,
  input wire logic              cfg_rvalid,
  input wire logic              sb_wr,
  // Decoded controls
  input wire logic [NPORTS-1:0] relaxed_order_off,
  input wire logic [NPORTS-1:0] port_disabled,
  input wire logic [NPORTS-1:0] retrain_on_err_off,
  input wire logic [NPORTS*2-1:0] rate_change_attempt_count,
  input wire logic [NPORTS*7-1:0] phy_lane_mode,
  input wire logic              upstream_cfg_keep,
  input wire logic [16:0]       phy_delta,
  input wire logic [15:0]       phy_tx_margin,
  input wire logic [15:0]       strap_modes,
  input wire logic [6:0]        reference_clock_outputs_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // Read handshake: one answer, one cycle later, zero when idle
  AST_RD_ANSWER: assert property (cfg_rd |=> cfg_rvalid)
    else $error("read not answered");
  AST_RD_ONLY: assert property (cfg_rvalid |-> $past(cfg_rd))
    else $error("answer without read");
  AST_RDATA_IDLE: assert property (!cfg_rvalid |-> cfg_rdata == 32'h0000_0000)
    else $error("read data not zero when idle");
  AST_UNMAPPED: assert property (cfg_rd && cfg_addr == 8'h9C |=> cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // Defaults straight after reset
  AST_RST_TLC: assert property ($fell(sys_rst) |-> port_disabled == 0 && rate_change_attempt_count == 0
    && phy_lane_mode == 0 && relaxed_order_off == 0 && &retrain_on_err_off && upstream_cfg_keep
    && phy_delta == 17'h0_0001) else $error("control defaults wrong");
  AST_RST_OPM: assert property ($fell(sys_rst) |-> strap_modes == 16'h0122
    && reference_clock_outputs_en == 7'h1F) else $error("mode defaults wrong");
  // Read-only fields move only after a sideband load
  AST_RO_HOLD: assert property (!sb_wr |-> ##2 $stable({port_disabled, retrain_on_err_off,
    rate_change_attempt_count, phy_lane_mode, upstream_cfg_keep, phy_delta, phy_tx_margin,
    strap_modes, reference_clock_outputs_en})) else $error("read-only field changed");
  // Ordering disable follows an upstream write, on all ports
  AST_RELAX_WR: assert property ((cfg_wr && !sb_wr && cfg_port == 2'd0 &&
    cfg_addr == `SPVCR_OFS_TLC && cfg_wdata[6]) ##1 !(cfg_wr || sb_wr) |=> &relaxed_order_off)
    else $error("ordering disable not applied");
  AST_RELAX_HOLD: assert property (!(cfg_wr || sb_wr) |-> ##2 $stable(relaxed_order_off))
    else $error("ordering disable moved");
endmodule
bind spvcr_regs spvcr_props #(.NPORTS(NPORTS)) u_props (.*);

// ---- verif/switch_port_vendor_config_regs_bench.sv ----
// Self-checking bench for the port vendor config bank
`timescale 1ns/1ns
`include "spvcr_cfg.svh"
module switch_port_vendor_config_regs_bench;
  logic        core_clk = 0, sys_rst = 1, strap = 1, cfg_wr = 0, cfg_rd = 0, sb_wr = 0, rvalid, keep, pd;
  logic [1:0]  cfg_port = 0, sb_port = 0;
  logic [7:0]  cfg_addr = 0, sb_addr = 0;
  logic [31:0] cfg_wdata = 0, sb_wdata = 0, rdata, r, w, v, mem[3][4];
  logic [2:0]  ro_off, pdis, rtr;
  logic [5:0]  rcnt;
  logic [20:0] lane;
  logic [16:0] delta;
  logic [15:0] margin, straps;
  logic [6:0]  ref_en;
  int          seed = 52, n_errors = 0, check_count = 0;
  localparam logic [31:0] VM[4] = '{`SPVCR_TLC_VMASK, `SPVCR_PHY3_VMASK, `SPVCR_PHY4_VMASK, `SPVCR_OPM_VMASK};
  localparam logic [31:0] UM[4] = '{`SPVCR_TLC_UPMASK, `SPVCR_PHY3_UPMASK, 32'hFFFF_FFFF, `SPVCR_OPM_UPMASK};
  localparam logic [31:0] RV[4] = '{`SPVCR_RST_TLC, `SPVCR_RST_PHY3, `SPVCR_RST_PHY4, `SPVCR_RST_OPM};
  localparam logic [7:0] OF[4] = '{`SPVCR_OFS_TLC, `SPVCR_OFS_PHY3, `SPVCR_OFS_PHY4, `SPVCR_OFS_OPM};
  spvcr_regs uut (.core_clk(core_clk), .sys_rst(sys_rst), .clock_buffer_powerdown_strap(strap),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_port(cfg_port), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(rdata), .cfg_rvalid(rvalid), .sb_wr(sb_wr), .sb_port(sb_port), .sb_addr(sb_addr),
    .sb_wdata(sb_wdata), .relaxed_order_off(ro_off), .port_disabled(pdis), .retrain_on_err_off(rtr),
    .rate_change_attempt_count(rcnt), .phy_lane_mode(lane), .upstream_cfg_keep(keep), .phy_delta(delta),
    .phy_tx_margin(margin), .strap_modes(straps), .reference_clock_outputs_en(ref_en),
    .reference_clock_outputs_pd(pd));
  // 25 MHz clock
  always #20 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////
  // Expected read: upstream-only fields come from port 0
  function automatic logic [31:0] exp_rd(int p, int i);
    return (mem[p][i] & ~UM[i]) | (mem[0][i] & UM[i]);
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One request (0 read, 1 config write, 2 sideband load, 3 both writes), then all decoded outputs
  task automatic op(int k, int p, int i, logic [31:0] d);
    {cfg_port, cfg_addr, cfg_wdata} = {2'(p), (i < 4) ? OF[i] : 8'h9C, d};
    {sb_port, sb_addr, sb_wdata} = {2'(p), (i < 4) ? OF[i] : 8'h9C, d};
    {cfg_rd, cfg_wr, sb_wr} = {k == 0, k == 1 || k == 3, k >= 2};
    @(negedge core_clk);
    {cfg_rd, cfg_wr, sb_wr} = 3'b000;
    if (k == 0) begin
      chk({31'h0, rvalid}, 32'h0000_0001);
      chk(rdata, (i < 4) ? exp_rd(p, i) : 32'h0000_0000);
    end
    else if (k >= 2 && i < 4) mem[p][i] = d & VM[i];
    else if (i == 0) mem[p][0] = (mem[p][0] & ~`SPVCR_TLC_WMASK) | (d & `SPVCR_TLC_WMASK);
    @(negedge core_clk);
    chk(ro_off, {3{mem[0][0][6]}});
    chk({keep, delta, margin}, {mem[0][0][11], mem[0][1][31:15], mem[0][2][15:0]});
    chk({pd, ref_en, straps}, mem[0][3][23:0]);
    for (int q = 0; q < 3; q++) begin
      w = exp_rd(q, 0);
      v = mem[q][1];
      chk({pdis[q], rtr[q], rcnt[2*q+:2], lane[7*q+:7]}, {w[10], w[16], w[9:8], v[6:0]});
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Main sequence: defaults, refused writes, sideband, then random traffic
  initial begin
    for (int p = 0; p < 3; p++) for (int i = 0; i < 4; i++) mem[p][i] = RV[i] | ((i == 3) ? 32'h0080_0000 : 0);
    repeat (5) @(negedge core_clk);
    sys_rst = 0;
    repeat (6) @(negedge core_clk);
    for (int p = 0; p < 3; p++) for (int i = 0; i < 5; i++) op(0, p, i, 0);
    for (int i = 0; i < 5; i++) op(1, 0, i, 32'hFFFF_FFFF);
    op(1, 2, 0, 32'h0000_0000);
    op(2, 2, 0, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) op(0, 2, i, 0);
    // Both writers on one word: the sideband load must replace it whole
    op(3, 0, 0, 32'h0000_0040);
    op(0, 0, 0, 0);
    for (int n = 0; n < 300; n++) begin
      r = $random(seed);
      op(r[1:0], r[3:2] % 3, r[6:4] % 5, $random(seed));
    end
    // Second reset with the strap low: defaults return and clock outputs stay enabled
    strap = 0;
    sys_rst = 1;
    repeat (2) @(negedge core_clk);
    for (int p = 0; p < 3; p++) for (int i = 0; i < 4; i++) mem[p][i] = RV[i];
    sys_rst = 0;
    repeat (6) @(negedge core_clk);
    for (int p = 0; p < 3; p++) for (int i = 0; i < 4; i++) op(0, p, i, 0);
    complete_run;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run;
  end
endmodule
